// ===== core/dsd_decoder.sv
// data space decoder: maps cpu loads, stores and i/o instructions
// onto register file, i/o, extended i/o and internal sram, and
// stretches the cpu halt for eeprom reads and writes.
// assumes one outstanding request; the cpu waits for ack.
`timescale 1ns/1ns
module dsd_decoder #(
  parameter int SRAM_BYTES = dsd_pkg::SRAM_BYTES_DEF,
  parameter int EE_BYTES = dsd_pkg::EE_BYTES_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire dsd_pkg::dsd_kind_t req_kind,
  input wire dsd_pkg::dsd_mode_t req_mode,
  input wire dsd_pkg::dsd_ptr_t req_ptr,
  input wire logic [15:0] req_addr,
  input wire logic [5:0] req_disp,
  input wire logic [2:0] req_bit,
  input wire logic [7:0] req_wdata,
  input wire logic [15:0] ptr_x,
  input wire logic [15:0] ptr_y,
  input wire logic [15:0] ptr_z,
  input wire logic [7:0] dev_rdata,
  input wire logic ee_read_go,
  input wire logic ee_write_go,
  input wire logic ee_write_done,
  input wire logic [dsd_pkg::EE_AW-1:0] ee_addr,
  output logic ack_reg,
  output logic err_reg,
  output logic [7:0] rdata_reg,
  output logic skip_reg,
  output logic rf_sel_reg,
  output logic io_sel_reg,
  output logic xio_sel_reg,
  output logic sram_sel_reg,
  output logic [15:0] dev_addr_reg,
  output logic dev_we_reg,
  output logic [7:0] dev_wdata_reg,
  output logic [7:0] dev_wmask_reg,
  output logic ptr_wr_reg,
  output dsd_pkg::dsd_ptr_t ptr_wr_sel_reg,
  output logic [15:0] ptr_wr_val_reg,
  output logic stall_reg,
  output logic ee_prog_reg,
  output logic [dsd_pkg::EE_AW-1:0] ee_addr_reg
);
  import dsd_pkg::*;

  localparam int SAW = $clog2(SRAM_BYTES);
  localparam logic [15:0] SRAM_END = 16'(int'(SRAM_BASE) + SRAM_BYTES);
  localparam logic [EE_AW-1:0] EE_MASK = EE_AW'(EE_BYTES - 1);

  dsd_state_t state_reg;
  dsd_kind_t kind_reg;
  logic [2:0] bit_reg;
  logic [2:0] stall_cnt_reg;

  logic [15:0] base_ptr;
  logic [15:0] eff_addr;
  logic [15:0] ptr_next;
  logic ptr_upd;
  logic is_port;
  logic is_bit;
  logic is_write;
  logic req_err;
  logic hit_rf;
  logic hit_io;
  logic hit_xio;
  logic hit_sram;
  logic [15:0] region_off;
  logic [7:0] bit_onehot;
  logic accept;

  dsd_mem_if #(.AW(SAW)) sram_port ();

  dsd_sram #(
    .BYTES(SRAM_BYTES),
    .AW(SAW)
  ) u_sram (
    .clk(clk),
    .port(sram_port)
  );

  // pick the pointer pair; x, y, z are R27:R26, R29:R28, R31:R30
  always_comb begin
    case (req_ptr)
      PTR_X: base_ptr = ptr_x;
      PTR_Y: base_ptr = ptr_y;
      default: base_ptr = ptr_z;
    endcase
  end

  // instruction class flags
  assign is_port = (req_kind == KIND_IO_IN) || (req_kind == KIND_IO_OUT);
  assign is_bit = (req_kind == KIND_BIT_SET) || (req_kind == KIND_BIT_CLR) ||
                  (req_kind == KIND_SKIP_SET) || (req_kind == KIND_SKIP_CLR);
  assign is_write = (req_kind == KIND_STORE) || (req_kind == KIND_IO_OUT) ||
                    (req_kind == KIND_BIT_SET) || (req_kind == KIND_BIT_CLR);
  assign bit_onehot = 8'(ONE_BIT << req_bit);

  // effective address and pointer write-back
  always_comb begin
    eff_addr = req_addr;
    ptr_next = base_ptr;
    ptr_upd = 1'b0;
    if (is_port || is_bit) begin
      eff_addr = req_addr + IO_PORT_OFFSET;
    end else begin
      case (req_mode)
        MODE_DIRECT: eff_addr = req_addr;
        MODE_IND: eff_addr = base_ptr;
        MODE_IND_DISP: eff_addr = base_ptr + {10'h000, req_disp};
        MODE_PRE_DEC: begin
          eff_addr = base_ptr - PTR_STEP;
          ptr_next = base_ptr - PTR_STEP;
          ptr_upd = 1'b1;
        end
        MODE_POST_INC: begin
          eff_addr = base_ptr;
          ptr_next = base_ptr + PTR_STEP;
          ptr_upd = 1'b1;
        end
        default: eff_addr = req_addr;
      endcase
    end
  end

  // region decode; at most one hit, none above the sram
  always_comb begin
    hit_rf = 1'b0;
    hit_io = 1'b0;
    hit_xio = 1'b0;
    hit_sram = 1'b0;
    region_off = eff_addr;
    if (eff_addr < IO_BASE) begin
      hit_rf = 1'b1;
      region_off = eff_addr - RF_BASE;
    end else if (eff_addr < XIO_BASE) begin
      hit_io = 1'b1;
      region_off = eff_addr - IO_BASE;
    end else if (eff_addr < SRAM_BASE) begin
      hit_xio = 1'b1;
      region_off = eff_addr - XIO_BASE;
    end else if (eff_addr < SRAM_END) begin
      hit_sram = 1'b1;
      region_off = eff_addr - SRAM_BASE;
    end
  end

  // refusals: port range, bit range, x with displacement, unmapped
  always_comb begin
    req_err = 1'b0;
    if (is_port && (req_addr > IO_PORT_LAST)) begin
      req_err = 1'b1;
    end else if (is_bit && (req_addr > BIT_IO_LAST)) begin
      req_err = 1'b1;
    end else if (!is_port && !is_bit && (req_mode == MODE_IND_DISP) &&
                 (req_ptr == PTR_X)) begin
      req_err = 1'b1;
    end else if (!(hit_rf || hit_io || hit_xio || hit_sram)) begin
      req_err = 1'b1;
    end
  end

  // no new access while one runs or the cpu is halted
  assign accept = req_valid && (state_reg == ST_IDLE) && !stall_reg;

  // access sequencer: two cycles of memory access per request
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept && !req_err) begin
            state_reg <= ST_MEM;
          end
        end
        ST_MEM: state_reg <= ST_DATA;
        ST_DATA: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // region selects, held through both access cycles
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rf_sel_reg <= 1'b0;
      io_sel_reg <= 1'b0;
      xio_sel_reg <= 1'b0;
      sram_sel_reg <= 1'b0;
    end else if (accept && !req_err) begin
      rf_sel_reg <= hit_rf;
      io_sel_reg <= hit_io;
      xio_sel_reg <= hit_xio;
      sram_sel_reg <= hit_sram;
    end else if (state_reg == ST_DATA) begin
      rf_sel_reg <= 1'b0;
      io_sel_reg <= 1'b0;
      xio_sel_reg <= 1'b0;
      sram_sel_reg <= 1'b0;
    end
  end

  // address, data and byte mask toward the regions
  // bit set and clear carry a one-hot mask and no read-modify-write, so a
  // flag that clears on a written one beside it is never hit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dev_addr_reg <= 16'h0000;
      dev_we_reg <= 1'b0;
      dev_wdata_reg <= 8'h00;
      dev_wmask_reg <= MASK_NONE;
      kind_reg <= KIND_LOAD;
      bit_reg <= 3'h0;
    end else if (accept && !req_err) begin
      dev_addr_reg <= region_off;
      dev_we_reg <= is_write;
      kind_reg <= req_kind;
      bit_reg <= req_bit;
      if (req_kind == KIND_BIT_SET) begin
        dev_wdata_reg <= bit_onehot;
        dev_wmask_reg <= bit_onehot;
      end else if (req_kind == KIND_BIT_CLR) begin
        dev_wdata_reg <= MASK_NONE;
        dev_wmask_reg <= bit_onehot;
      end else begin
        dev_wdata_reg <= req_wdata;
        dev_wmask_reg <= is_write ? MASK_ALL : MASK_NONE;
      end
    end else if (state_reg == ST_DATA) begin
      dev_we_reg <= 1'b0;
      dev_wmask_reg <= MASK_NONE;
    end
  end

  // sram is driven only in the first access cycle
  assign sram_port.en = sram_sel_reg && (state_reg == ST_MEM);
  assign sram_port.we = dev_we_reg;
  assign sram_port.addr = dev_addr_reg[SAW-1:0];
  assign sram_port.wdata = dev_wdata_reg;

  // answer: data, skip result and acknowledge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 8'h00;
      skip_reg <= 1'b0;
    end else begin
      ack_reg <= (state_reg == ST_DATA) || (accept && req_err);
      err_reg <= accept && req_err;
      skip_reg <= 1'b0;
      if (state_reg == ST_DATA) begin
        rdata_reg <= sram_sel_reg ? sram_port.rdata : dev_rdata;
        if (kind_reg == KIND_SKIP_SET) begin
          skip_reg <= dev_rdata[bit_reg];
        end else if (kind_reg == KIND_SKIP_CLR) begin
          skip_reg <= !dev_rdata[bit_reg];
        end
      end
    end
  end

  // pointer pair write-back, one pulse per updating access
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ptr_wr_reg <= 1'b0;
      ptr_wr_sel_reg <= PTR_X;
      ptr_wr_val_reg <= 16'h0000;
    end else begin
      ptr_wr_reg <= accept && !req_err && ptr_upd && !is_port && !is_bit;
      if (accept && ptr_upd) begin
        ptr_wr_sel_reg <= req_ptr;
        ptr_wr_val_reg <= ptr_next;
      end
    end
  end

  // eeprom halt counter; read outranks write if both start at once
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stall_cnt_reg <= STALL_NONE;
    end else if (ee_read_go) begin
      stall_cnt_reg <= EE_RD_STALL;
    end else if (ee_write_go) begin
      stall_cnt_reg <= EE_WR_STALL;
    end else if (stall_cnt_reg != STALL_NONE) begin
      stall_cnt_reg <= stall_cnt_reg - STALL_LAST;
    end
  end

  // halt flag, high exactly while the counter runs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stall_reg <= 1'b0;
    end else if (ee_read_go || ee_write_go) begin
      stall_reg <= 1'b1;
    end else if (stall_cnt_reg == STALL_LAST) begin
      stall_reg <= 1'b0;
    end
  end

  // programming in progress; reset does not abort a running write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ee_prog_reg <= ee_prog_reg && !ee_write_done;
    end else if (ee_write_go) begin
      ee_prog_reg <= 1'b1;
    end else if (ee_write_done) begin
      ee_prog_reg <= 1'b0;
    end
  end

  // eeprom byte address, wrapped to its own space, frozen while writing
  always_ff @(posedge clk) begin
    if (!rst_b && !ee_prog_reg) begin
      ee_addr_reg <= '0;
    end else if ((ee_read_go || ee_write_go) && !ee_prog_reg) begin
      ee_addr_reg <= ee_addr & EE_MASK;
    end
  end

endmodule : dsd_decoder

// ===== pkg/dsd_pkg.sv
// constants, modes and states for the data space decoder
// assumes a 16-bit data address and byte-wide data
package dsd_pkg;

  // region bases in the data space
  localparam logic [15:0] RF_BASE = 16'h0000;
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] XIO_BASE = 16'h0060;
  localparam logic [15:0] SRAM_BASE = 16'h0100;
  // offset added to a short i/o port address
  localparam logic [15:0] IO_PORT_OFFSET = 16'h0020;
  // last address of the short i/o port range and of the bit range
  localparam logic [15:0] IO_PORT_LAST = 16'h003F;
  localparam logic [15:0] BIT_IO_LAST = 16'h001F;
  // pointer step for pre-decrement and post-increment
  localparam logic [15:0] PTR_STEP = 16'h0001;
  // default sizes of the variant
  localparam int SRAM_BYTES_DEF = 1024;
  localparam int EE_BYTES_DEF = 512;
  localparam int EE_AW = 10;
  // cpu halt lengths in clock cycles
  localparam logic [2:0] EE_RD_STALL = 3'h4;
  localparam logic [2:0] EE_WR_STALL = 3'h2;
  localparam logic [2:0] STALL_LAST = 3'h1;
  localparam logic [2:0] STALL_NONE = 3'h0;
  // full and empty byte write masks and the one-bit seed of bit masks
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] ONE_BIT = 8'h01;

  typedef enum logic [2:0] {
    KIND_LOAD,
    KIND_STORE,
    KIND_IO_IN,
    KIND_IO_OUT,
    KIND_BIT_SET,
    KIND_BIT_CLR,
    KIND_SKIP_SET,
    KIND_SKIP_CLR
  } dsd_kind_t;

  typedef enum logic [2:0] {
    MODE_DIRECT,
    MODE_IND,
    MODE_IND_DISP,
    MODE_PRE_DEC,
    MODE_POST_INC
  } dsd_mode_t;

  typedef enum logic [1:0] {
    PTR_X,
    PTR_Y,
    PTR_Z
  } dsd_ptr_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MEM,
    ST_DATA
  } dsd_state_t;

endpackage : dsd_pkg

// ===== pkg/dsd_mem_if.sv
// port bundle between the decoder and its internal data sram
// assumes one clock; read data comes back one edge after enable
`timescale 1ns/1ns
interface dsd_mem_if #(
  parameter int AW = 10
);
  logic en;
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : dsd_mem_if

// ===== core/dsd_sram.sv
// internal data sram, byte wide, registered read data
// assumes the decoder holds enable for one cycle per access
`timescale 1ns/1ns
module dsd_sram #(
  parameter int BYTES = 1024,
  parameter int AW = 10
) (
  input wire logic clk,
  dsd_mem_if.mem port
);
  import dsd_pkg::*;

  logic [7:0] mem_array [BYTES];

  // write and read share the one enable; read data is registered
  always_ff @(posedge clk) begin
    if (port.en) begin
      if (port.we) begin
        mem_array[port.addr] <= port.wdata;
      end
      port.rdata <= mem_array[port.addr];
    end
  end
endmodule : dsd_sram

// ===== tb/dsd_decoder_properties.sv
// checker for the data space decoder, watching its top ports only
// assumes the cpu never requests in the cycle that carries ack
`timescale 1ns/1ns
module dsd_chk
  import dsd_pkg::*;
#(
  parameter int SRAM_BYTES = 1024
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire dsd_pkg::dsd_kind_t req_kind,
  input wire dsd_pkg::dsd_mode_t req_mode,
  input wire dsd_pkg::dsd_ptr_t req_ptr,
  input wire logic [15:0] req_addr,
  input wire logic [2:0] req_bit,
  input wire logic [15:0] ptr_x,
  input wire logic ee_read_go,
  input wire logic ee_write_go,
  input wire logic ee_write_done,
  input wire logic ack_reg,
  input wire logic err_reg,
  input wire logic rf_sel_reg,
  input wire logic io_sel_reg,
  input wire logic xio_sel_reg,
  input wire logic sram_sel_reg,
  input wire logic [15:0] dev_addr_reg,
  input wire logic dev_we_reg,
  input wire logic [7:0] dev_wmask_reg,
  input wire logic ptr_wr_reg,
  input wire logic [15:0] ptr_wr_val_reg,
  input wire logic stall_reg,
  input wire logic ee_prog_reg
);
  logic busy_reg;
  logic acc;
  // a request the sequencer takes: idle and not halted
  assign acc = req_valid && !stall_reg && !busy_reg && !ack_reg;
  // one access in flight until its answer shows
  always_ff @(posedge clk) begin
    if (!rst_b || ack_reg) begin
      busy_reg <= 1'b0;
    end else if (acc) begin
      busy_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_region_onehot: assert property (
    $onehot0({rf_sel_reg, io_sel_reg, xio_sel_reg, sram_sel_reg})) else $error("two selects");
  a_sram_two_cycles: assert property (
    $rose(sram_sel_reg) |-> sram_sel_reg [*2] ##1 (!sram_sel_reg && ack_reg)) else $error("sram time");
  a_io_port_offset: assert property (
    acc && req_kind == KIND_IO_IN && req_addr <= IO_PORT_LAST
    |=> io_sel_reg && dev_addr_reg == $past(req_addr)) else $error("port offset");
  a_refuse_range: assert property (
    acc && ((req_kind inside {KIND_IO_IN, KIND_IO_OUT} && req_addr > IO_PORT_LAST) ||
    (req_kind inside {KIND_BIT_SET, KIND_BIT_CLR, KIND_SKIP_SET, KIND_SKIP_CLR} &&
    req_addr > BIT_IO_LAST)) |=> ack_reg && err_reg && !xio_sel_reg) else $error("no refusal");
  a_xio_map: assert property (
    acc && req_mode == MODE_DIRECT && req_kind == KIND_LOAD && req_addr inside
    {[XIO_BASE:16'h00FF]} |=> xio_sel_reg && dev_addr_reg == $past(req_addr) - XIO_BASE)
    else $error("xio map");
  a_sram_map: assert property (
    acc && req_mode == MODE_DIRECT && req_kind == KIND_LOAD && req_addr >= SRAM_BASE &&
    req_addr < SRAM_BASE + SRAM_BYTES |=> sram_sel_reg ##2 (ack_reg && !err_reg))
    else $error("sram map");
  a_ptr_step: assert property (
    acc && req_ptr == PTR_X && req_mode == MODE_POST_INC && req_kind == KIND_LOAD
    |=> ptr_wr_reg && ptr_wr_val_reg == $past(ptr_x) + PTR_STEP) else $error("ptr step");
  a_bit_mask: assert property (
    acc && req_kind == KIND_BIT_SET && req_addr <= BIT_IO_LAST
    |=> dev_we_reg && dev_wmask_reg == (ONE_BIT << $past(req_bit))) else $error("bit mask");
  a_ee_read_halt: assert property (
    ee_read_go |=> stall_reg [*4] ##1 !stall_reg) else $error("read halt");
  a_ee_write_halt: assert property (
    ee_write_go && !ee_read_go |=> stall_reg [*2] ##1 !stall_reg) else $error("write halt");
  a_ee_prog_hold: assert property (
    disable iff (1'b0) ee_prog_reg && !ee_write_done |=> ee_prog_reg) else $error("prog lost");
endmodule : dsd_chk

bind dsd_decoder dsd_chk #(.SRAM_BYTES(SRAM_BYTES)) u_chk (.*);

// ===== tb/dsd_cpu_model.sv
// cpu side model: pointer pairs and the register and i/o byte source
// assumes the decoder writes a pointer pair as one 16-bit value
`timescale 1ns/1ns
module dsd_cpu_model
  import dsd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ptr_wr_reg,
  input wire dsd_pkg::dsd_ptr_t ptr_wr_sel_reg,
  input wire logic [15:0] ptr_wr_val_reg,
  input wire logic rf_sel_reg,
  input wire logic io_sel_reg,
  input wire logic xio_sel_reg,
  input wire logic [15:0] dev_addr_reg,
  output logic [15:0] ptr_x,
  output logic [15:0] ptr_y,
  output logic [15:0] ptr_z,
  output logic [7:0] dev_rdata
);
  logic [7:0] junk_reg;
  // pairs r27:r26, r29:r28, r31:r30 take the whole new value at once
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ptr_x <= 16'h0100;
      ptr_y <= 16'h0140;
      ptr_z <= 16'h0200;
    end else if (ptr_wr_reg) begin
      case (ptr_wr_sel_reg)
        PTR_X: ptr_x <= ptr_wr_val_reg;
        PTR_Y: ptr_y <= ptr_wr_val_reg;
        default: ptr_z <= ptr_wr_val_reg;
      endcase
    end
  end
  // moving pattern when unselected, so a stale byte never passes
  always_ff @(posedge clk) junk_reg <= rst_b ? junk_reg + 8'h01 : 8'h00;
  assign dev_rdata = (rf_sel_reg || io_sel_reg || xio_sel_reg) ?
                     dev_addr_reg[7:0] ^ 8'h5A : junk_reg;
endmodule : dsd_cpu_model

// ===== tb/tb_top.sv
// self-checking bench for the data space decoder with a cpu-side model
// assumes the decoder holds its own sram and answers each request by ack
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import dsd_pkg::*;
  localparam int SB = 1024;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  dsd_kind_t req_kind = KIND_LOAD;
  dsd_mode_t req_mode = MODE_DIRECT;
  dsd_ptr_t req_ptr = PTR_X;
  logic [15:0] req_addr = 16'h0000;
  logic [5:0] req_disp = 6'h00;
  logic [2:0] req_bit = 3'h0;
  logic [7:0] req_wdata = 8'h00;
  logic ee_read_go = 1'b0;
  logic ee_write_go = 1'b0;
  logic ee_write_done = 1'b1; // idle eeprom reports done so power-up reset clears prog
  logic [EE_AW-1:0] ee_addr = 10'h000;
  logic [EE_AW-1:0] ee_addr_reg;
  logic [15:0] ptr_x, ptr_y, ptr_z, dev_addr_reg, ptr_wr_val_reg, off, pv;
  logic [7:0] dev_rdata, rdata_reg, dev_wdata_reg, dev_wmask_reg, msk, wd, rd;
  logic ack_reg, err_reg, skip_reg, rf_sel_reg, io_sel_reg, xio_sel_reg, sram_sel_reg;
  logic dev_we_reg, ptr_wr_reg, stall_reg, ee_prog_reg, we, pw, er, sk;
  logic [3:0] sel;
  dsd_ptr_t ptr_wr_sel_reg;
  int n_mismatch = 0;
  int compares = 0;

  dsd_decoder #(.SRAM_BYTES(SB), .EE_BYTES(EE_BYTES_DEF)) dut (.*);
  dsd_cpu_model u_cpu (.*);

  // free-running 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end

  task automatic end_sim();
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  // one request held a single cycle, then a bounded wait for the answer
  task automatic acc(input dsd_kind_t k, input dsd_mode_t m, input dsd_ptr_t p,
                     input logic [15:0] a, input logic [5:0] d, input logic [7:0] w);
    int i;
    req_kind = k;
    req_mode = m;
    req_ptr = p;
    req_addr = a;
    req_disp = d;
    req_bit = d[2:0];
    req_wdata = w;
    req_valid = 1'b1;
    tick();
    req_valid = 1'b0;
    {sel, off, we, msk, wd, pw, pv} = {rf_sel_reg, io_sel_reg, xio_sel_reg, sram_sel_reg,
      dev_addr_reg, dev_we_reg, dev_wmask_reg, dev_wdata_reg, ptr_wr_reg, ptr_wr_val_reg};
    for (i = 0; i < 6 && ack_reg !== 1'b1; i++) tick();
    if (ack_reg !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
    {er, rd, sk} = {err_reg, rdata_reg, skip_reg};
    tick();
  endtask : acc

  task automatic s_map();
    logic [15:0] ad[6] = '{16'h0000, 16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF};
    logic [3:0] es[6] = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h2, 4'h2};
    logic [15:0] eo[6] = '{16'h0000, 16'h001F, 16'h0000, 16'h003F, 16'h0000, 16'h009F};
    for (int i = 0; i < 6; i++) begin
      acc(KIND_LOAD, MODE_DIRECT, PTR_X, ad[i], 6'h00, 8'h00);
      `CHK("region", es[i], sel)
      `CHK("offset", eo[i], off)
      `CHK("rdata", eo[i][7:0] ^ 8'h5A, rd)
    end
  endtask : s_map

  task automatic s_sram();
    logic [15:0] ad[3] = '{16'h0100, 16'h017F, 16'(SRAM_BASE + SB - 1)};
    logic [7:0] dt[3] = '{8'hAB, 8'hC3, 8'h5E};
    for (int i = 0; i < 6; i++) begin
      acc(i < 3 ? KIND_STORE : KIND_LOAD, MODE_DIRECT, PTR_X, ad[i % 3], 6'h00, dt[i % 3]);
      `CHK("sram sel", 4'h1, sel)
      if (i >= 3) `CHK("sram data", dt[i % 3], rd)
    end
    acc(KIND_LOAD, MODE_DIRECT, PTR_X, 16'(SRAM_BASE + SB), 6'h00, 8'h00);
    `CHK("unmapped", 1'b1, er)
  endtask : s_sram

  task automatic s_port();
    acc(KIND_IO_IN, MODE_DIRECT, PTR_X, IO_PORT_LAST, 6'h00, 8'h00);
    `CHK("port sel", 4'h4, sel)
    `CHK("port data", 8'h65, rd)
    acc(KIND_IO_OUT, MODE_DIRECT, PTR_X, 16'h0040, 6'h00, 8'h11);
    `CHK("port xio err", 1'b1, er)
    acc(KIND_STORE, MODE_DIRECT, PTR_X, XIO_BASE, 6'h00, 8'h3C);
    `CHK("xio sel", 4'h2, sel)
    `CHK("xio mask", MASK_ALL, msk)
    `CHK("xio we", 1'b1, we)
    `CHK("xio data", 8'h3C, wd)
  endtask : s_port

  task automatic s_ptr();
    acc(KIND_LOAD, MODE_POST_INC, PTR_X, 16'h0000, 6'h00, 8'h00);
    `CHK("post data", 8'hAB, rd)
    `CHK("post ptr", 16'h0101, pv)
    acc(KIND_STORE, MODE_POST_INC, PTR_X, 16'h0000, 6'h00, 8'h00);
    `CHK("x pair", 16'h0102, ptr_x)
    acc(KIND_LOAD, MODE_PRE_DEC, PTR_Z, 16'h0000, 6'h00, 8'h00);
    `CHK("pre ptr", 16'h01FF, pv)
    `CHK("pre off", 16'h00FF, off)
    acc(KIND_LOAD, MODE_IND_DISP, PTR_Y, 16'h0000, 6'h3F, 8'h00);
    `CHK("disp data", 8'hC3, rd)
    `CHK("disp no ptr", 1'b0, pw)
    acc(KIND_LOAD, MODE_IND, PTR_Y, 16'h0000, 6'h00, 8'h00);
    `CHK("ind off", 16'h0040, off)
    `CHK("ind no ptr", 1'b0, pw)
    acc(KIND_LOAD, MODE_IND_DISP, PTR_X, 16'h0000, 6'h01, 8'h00);
    `CHK("disp x err", 1'b1, er)
  endtask : s_ptr

  task automatic s_bit();
    acc(KIND_BIT_SET, MODE_DIRECT, PTR_X, BIT_IO_LAST, 6'h07, 8'h00);
    `CHK("set mask", 8'h80, msk)
    `CHK("set data", 8'h80, wd)
    acc(KIND_BIT_CLR, MODE_DIRECT, PTR_X, BIT_IO_LAST, 6'h02, 8'h00);
    `CHK("clr mask", 8'h04, msk)
    `CHK("clr data", 8'h00, wd)
    acc(KIND_SKIP_SET, MODE_DIRECT, PTR_X, BIT_IO_LAST, 6'h00, 8'h00);
    `CHK("skip set", 1'b1, sk)
    acc(KIND_SKIP_CLR, MODE_DIRECT, PTR_X, BIT_IO_LAST, 6'h01, 8'h00);
    `CHK("skip clr", 1'b1, sk)
    acc(KIND_BIT_SET, MODE_DIRECT, PTR_X, 16'h0020, 6'h00, 8'h00);
    `CHK("bit range", 1'b1, er)
  endtask : s_bit

  // halt counts; a request made during the halt must go unanswered
  task automatic s_ee();
    int n;
    n = 0;
    ee_read_go = 1'b1;
    tick();
    {ee_read_go, req_valid} = 2'b01;
    for (int i = 0; i < 8; i++) begin
      n += (stall_reg === 1'b1) + 16 * (ack_reg === 1'b1);
      tick();
      req_valid = 1'b0;
    end
    `CHK("read halt", 32'd4, n)
    {n, ee_write_go, ee_addr} = {32'd0, 1'b1, 10'h1FF};
    tick();
    ee_write_go = 1'b0;
    for (int i = 0; i < 6; i++) begin
      n += (stall_reg === 1'b1);
      tick();
    end
    `CHK("write halt", 32'd2, n)
    `CHK("ee addr", 10'h1FF, ee_addr_reg)
    rst_b = 1'b0;
    repeat (3) tick();
    `CHK("prog in reset", 1'b1, ee_prog_reg)
    {rst_b, ee_write_done} = 2'b11;
    tick();
    ee_write_done = 1'b0;
    tick();
    `CHK("prog done", 1'b0, ee_prog_reg)
  endtask : s_ee

  // reset, then each scenario in turn
  initial begin
    repeat (20) tick();
    rst_b = 1'b1;
    ee_write_done = 1'b0;
    s_map();
    s_sram();
    s_port();
    s_ptr();
    s_bit();
    s_ee();
    end_sim();
  end
endmodule : tb_top
